// ---- hdl/ircfg_top.sv ----
// Purpose: Input receiver configuration registers behind AXI4-Lite.
// Assumes: One 10 MHz clock, synchronous active-high reset.
// Notes:   Register index times four is the byte address.
//
// Summary of operation
// - Input control bit 7 enables the test reference receiver; off at reset.
// - Input control bit 6 puts secondary reference in differential mode.
// - Input control bit 5 puts primary reference in differential mode.
// - Input control bit 2 clear keeps both reference receivers powered.
// - With bit 2 set, bits 4 and 3 enable secondary and primary.
// - Input control bit 1 picks oscillator negative pin in single-ended mode.
// - Input control bit 0 puts oscillator receiver in differential mode.
// - Feedback bit 5 applies only while bit 4 is clear.
// - Internal zero delay powers feedback receiver down; external enables it.
// - Feedback bit 4 uses oscillator feedback; clear enables zero delay.
// - Feedback bit 2 puts zero-delay receiver in differential mode.
// - Feedback bit 3 picks zero-delay single-ended pin while bit 2 clear.
// - Feedback bit 1 picks secondary pin while input bit 6 is clear.
// - Feedback bit 0 picks primary single-ended pin while input bit 5 clear.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module ircfg_top
  import ircfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   test_rx_en_q,
  output logic                   pri_rx_en_q,
  output logic                   sec_rx_en_q,
  output logic                   pri_diff_q,
  output logic                   sec_diff_q,
  output logic                   pri_pin_sel_q,
  output logic                   sec_pin_sel_q,
  output logic                   osc_diff_q,
  output logic                   osc_neg_sel_q,
  output logic                   zd_rx_en_q,
  output logic                   zd_diff_q,
  output logic                   zd_pin_sel_q,
  output ircfg_fb_t              fb_src_q
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]        irc_q;
  logic [7:0]        fbc_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wstrb0_q;

  wire logic              aw_take;
  wire logic              w_take;
  wire logic              wr_go;
  wire logic [ADDR_W-1:0] wr_addr;
  wire logic [7:0]        wr_byte;
  wire logic              wr_lane0;
  wire logic              wr_hit_irc;
  wire logic              wr_hit_fbc;
  wire logic              ar_take;
  wire logic [7:0]        rd_byte;
  wire logic              rd_hit;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are latched independently, so either may come first.
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_byte  = w_held_q ? wbyte_q : s_axi_wdata[7:0];
  assign wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  assign wr_go    = (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_hit_irc = hit(wr_addr, IRC_ADDR);
  assign wr_hit_fbc = hit(wr_addr, FBC_ADDR);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wbyte_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_held_q && !w_take && !s_axi_bvalid && !wr_go;
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wbyte_q  <= s_axi_wdata[7:0];
          wstrb0_q <= s_axi_wstrb[0];
        end
      end
    end
  end

  // Unmapped writes are answered with an error and change nothing.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit_irc || wr_hit_fbc) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only byte lane 0 carries register bits; upper lanes are ignored.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irc_q <= IRC_RESET;
      fbc_q <= FBC_RESET;
    end else if (wr_go && wr_lane0) begin
      if (wr_hit_irc) begin
        irc_q <= wr_byte;
      end
      if (wr_hit_fbc) begin
        fbc_q <= wr_byte & FBC_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit  = hit(s_axi_araddr, IRC_ADDR) ||
                   hit(s_axi_araddr, FBC_ADDR);
  assign rd_byte = hit(s_axi_araddr, IRC_ADDR) ? irc_q :
                   hit(s_axi_araddr, FBC_ADDR) ? fbc_q : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ircfg_decode u_decode (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .irc           (irc_q),
    .fbc           (fbc_q),
    .test_rx_en_q  (test_rx_en_q),
    .pri_rx_en_q   (pri_rx_en_q),
    .sec_rx_en_q   (sec_rx_en_q),
    .pri_diff_q    (pri_diff_q),
    .sec_diff_q    (sec_diff_q),
    .pri_pin_sel_q (pri_pin_sel_q),
    .sec_pin_sel_q (sec_pin_sel_q),
    .osc_diff_q    (osc_diff_q),
    .osc_neg_sel_q (osc_neg_sel_q),
    .zd_rx_en_q    (zd_rx_en_q),
    .zd_diff_q     (zd_diff_q),
    .zd_pin_sel_q  (zd_pin_sel_q),
    .fb_src_q      (fb_src_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  test_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 test_rx_en_q == $past(irc_q[IRC_TEST_EN]))
    else $error("test receiver enable does not follow its bit");

  sec_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(irc_q[IRC_B_DIFF]) |=> sec_diff_q)
    else $error("secondary differential mode late");

  pri_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(irc_q[IRC_A_DIFF]) |=> !pri_diff_q)
    else $error("primary single-ended mode late");

  pd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !irc_q[IRC_PD_CTL] |=> (pri_rx_en_q && sec_rx_en_q))
    else $error("receiver powered down without gate bit");

  indiv_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    irc_q[IRC_PD_CTL] |=> (sec_rx_en_q == $past(irc_q[IRC_B_EN]) &&
                           pri_rx_en_q == $past(irc_q[IRC_A_EN])))
    else $error("individual receiver enable wrong");

  osc_neg_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!irc_q[IRC_OSC_DIFF] && irc_q[IRC_OSC_NEG]) |=> osc_neg_sel_q)
    else $error("oscillator negative pin not selected");

  osc_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
    osc_diff_q |-> !osc_neg_sel_q)
    else $error("pin select active in differential mode");

  zd_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    fbc_q[FBC_OSC_FB] |=> fb_src_q == IRCFG_FB_OSC)
    else $error("zero delay mode honoured during oscillator feedback");

  zd_rx_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fb_src_q == IRCFG_FB_ZD_INT) |-> !zd_rx_en_q)
    else $error("feedback receiver on in internal mode");

  fb_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!fbc_q[FBC_OSC_FB] && !fbc_q[FBC_ZD_INT]) |=> zd_rx_en_q)
    else $error("external zero delay receiver not enabled");

  zd_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
    zd_diff_q |-> !zd_pin_sel_q)
    else $error("zero delay pin select in differential mode");

  zd_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!fbc_q[FBC_ZD_DIFF] && fbc_q[FBC_ZD_PIN]) |=> zd_pin_sel_q)
    else $error("zero delay pin select wrong");

  sec_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!irc_q[IRC_B_DIFF]) |=> sec_pin_sel_q == $past(fbc_q[FBC_B_PIN]))
    else $error("secondary pin select wrong");

  pri_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!irc_q[IRC_A_DIFF]) |=> pri_pin_sel_q == $past(fbc_q[FBC_A_PIN]))
    else $error("primary pin select wrong");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    fbc_q[7:6] == 2'h0)
    else $error("reserved feedback bits not zero");

  wr_irc_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_go && wr_lane0 && wr_hit_irc) |=> irc_q == $past(wr_byte))
    else $error("input control write lost");

  wr_fbc_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_go && wr_lane0 && wr_hit_fbc) |=>
      fbc_q == {2'h0, $past(wr_byte[5:0])})
    else $error("feedback control write lost");

  irc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_go && wr_lane0 && wr_hit_irc) |=> $stable(irc_q))
    else $error("input control changed without a write");

  fbc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_go && wr_lane0 && wr_hit_fbc) |=> $stable(fbc_q))
    else $error("feedback control changed without a write");

  b_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

  wr_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_go && !wr_hit_irc && !wr_hit_fbc) |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  b_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not withdrawn");

  w_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write accepted while response pending");

  r_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
    ar_take |=> s_axi_rvalid)
    else $error("read response missing");

  r_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read response not withdrawn");

  ar_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while response pending");

  rd_irc_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ar_take && hit(s_axi_araddr, IRC_ADDR)) |=>
      s_axi_rdata == {24'h00_0000, $past(irc_q)})
    else $error("input control read back wrong");

  rd_fbc_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ar_take && hit(s_axi_araddr, FBC_ADDR)) |=>
      s_axi_rdata == {24'h00_0000, $past(fbc_q)})
    else $error("feedback control read back wrong");

  rd_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ar_take && !rd_hit) |=>
      (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read not refused");

endmodule : ircfg_top

// ---- hdl/ircfg_pkg.sv ----
// Purpose: Constants for the input receiver configuration block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Register numbers are word indices; byte address is four times.
package ircfg_pkg;

  localparam logic [7:0]  IRC_IDX      = 8'h1A;
  localparam logic [7:0]  FBC_IDX      = 8'h1B;
  localparam logic [11:0] IRC_ADDR     = {2'h0, IRC_IDX, 2'h0};
  localparam logic [11:0] FBC_ADDR     = {2'h0, FBC_IDX, 2'h0};
  localparam int          ADDR_W       = 12;

  localparam logic [7:0]  IRC_RESET    = 8'h00;
  localparam logic [7:0]  FBC_RESET    = 8'h00;
  localparam logic [7:0]  FBC_WMASK    = 8'h3F;

  localparam int          IRC_TEST_EN  = 7;
  localparam int          IRC_B_DIFF   = 6;
  localparam int          IRC_A_DIFF   = 5;
  localparam int          IRC_B_EN     = 4;
  localparam int          IRC_A_EN     = 3;
  localparam int          IRC_PD_CTL   = 2;
  localparam int          IRC_OSC_NEG  = 1;
  localparam int          IRC_OSC_DIFF = 0;

  localparam int          FBC_ZD_INT   = 5;
  localparam int          FBC_OSC_FB   = 4;
  localparam int          FBC_ZD_PIN   = 3;
  localparam int          FBC_ZD_DIFF  = 2;
  localparam int          FBC_B_PIN    = 1;
  localparam int          FBC_A_PIN    = 0;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    IRCFG_FB_OSC,
    IRCFG_FB_ZD_INT,
    IRCFG_FB_ZD_EXT
  } ircfg_fb_t;

endpackage : ircfg_pkg

// ---- hdl/ircfg_decode.sv ----
// Purpose: Turns the two register values into receiver control levels.
// Assumes: Inputs come from registers on the same clock.
// Notes:   Outputs are registered so the top drives them from flip-flops.
`timescale 1ns/1ps
module ircfg_decode
  import ircfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] irc,
  input  wire logic [7:0] fbc,
  output logic            test_rx_en_q,
  output logic            pri_rx_en_q,
  output logic            sec_rx_en_q,
  output logic            pri_diff_q,
  output logic            sec_diff_q,
  output logic            pri_pin_sel_q,
  output logic            sec_pin_sel_q,
  output logic            osc_diff_q,
  output logic            osc_neg_sel_q,
  output logic            zd_rx_en_q,
  output logic            zd_diff_q,
  output logic            zd_pin_sel_q,
  output ircfg_fb_t       fb_src_q
);

  ////////////////////////////////////////////////////////////////////////////
  wire logic      pri_en_d;
  wire logic      sec_en_d;
  wire logic      zd_en_d;
  wire ircfg_fb_t fb_d;

  // Without the gate bit both references stay powered.
  assign pri_en_d = !irc[IRC_PD_CTL] || irc[IRC_A_EN];
  assign sec_en_d = !irc[IRC_PD_CTL] || irc[IRC_B_EN];
  // Mode bit is ignored while oscillator feedback is chosen.
  assign fb_d = fbc[FBC_OSC_FB] ? IRCFG_FB_OSC :
                fbc[FBC_ZD_INT] ? IRCFG_FB_ZD_INT : IRCFG_FB_ZD_EXT;
  // Internal path powers the feedback receiver down.
  assign zd_en_d = (fb_d == IRCFG_FB_ZD_EXT);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_rx_en_q  <= 1'b0;
      pri_rx_en_q   <= 1'b1;
      sec_rx_en_q   <= 1'b1;
      pri_diff_q    <= 1'b0;
      sec_diff_q    <= 1'b0;
      pri_pin_sel_q <= 1'b0;
      sec_pin_sel_q <= 1'b0;
      osc_diff_q    <= 1'b0;
      osc_neg_sel_q <= 1'b0;
      zd_rx_en_q    <= 1'b1;
      zd_diff_q     <= 1'b0;
      zd_pin_sel_q  <= 1'b0;
      fb_src_q      <= IRCFG_FB_ZD_EXT;
    end else begin
      test_rx_en_q  <= irc[IRC_TEST_EN];
      pri_rx_en_q   <= pri_en_d;
      sec_rx_en_q   <= sec_en_d;
      pri_diff_q    <= irc[IRC_A_DIFF];
      sec_diff_q    <= irc[IRC_B_DIFF];
      // Pin choice only matters in single-ended mode.
      pri_pin_sel_q <= !irc[IRC_A_DIFF] && fbc[FBC_A_PIN];
      sec_pin_sel_q <= !irc[IRC_B_DIFF] && fbc[FBC_B_PIN];
      osc_diff_q    <= irc[IRC_OSC_DIFF];
      osc_neg_sel_q <= !irc[IRC_OSC_DIFF] && irc[IRC_OSC_NEG];
      zd_rx_en_q    <= zd_en_d;
      zd_diff_q     <= fbc[FBC_ZD_DIFF];
      zd_pin_sel_q  <= !fbc[FBC_ZD_DIFF] && fbc[FBC_ZD_PIN];
      fb_src_q      <= fb_d;
    end
  end

endmodule : ircfg_decode

// ---- tb/ircfg_tb.sv ----
// Purpose: Self-checking bench for the input receiver configuration block.
// Assumes: AXI4-Lite slave answers one cycle after a request is taken.
// Notes:   Receiver outputs are checked once the write response is taken.
`timescale 1ns/1ps
module testbench;
  import ircfg_pkg::*;

  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic              test_rx_en_q, pri_rx_en_q, sec_rx_en_q, pri_diff_q;
  logic              sec_diff_q, pri_pin_sel_q, sec_pin_sel_q, osc_diff_q;
  logic              osc_neg_sel_q, zd_rx_en_q, zd_diff_q, zd_pin_sel_q;
  ircfg_fb_t         fb_src_q;
  int                n_errors;
  int                n_compared;

  // Table of input control and feedback control pairs, upper byte first.
  localparam logic [15:0] TAB [0:6] = '{16'h840B, 16'h1E31, 16'h6B23,
    16'hFF3F, 16'h0214, 16'h1408, 16'hE127};

  ircfg_top uut (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .test_rx_en_q(test_rx_en_q),
    .pri_rx_en_q(pri_rx_en_q), .sec_rx_en_q(sec_rx_en_q),
    .pri_diff_q(pri_diff_q), .sec_diff_q(sec_diff_q),
    .pri_pin_sel_q(pri_pin_sel_q), .sec_pin_sel_q(sec_pin_sel_q),
    .osc_diff_q(osc_diff_q), .osc_neg_sel_q(osc_neg_sel_q),
    .zd_rx_en_q(zd_rx_en_q), .zd_diff_q(zd_diff_q),
    .zd_pin_sel_q(zd_pin_sel_q), .fb_src_q(fb_src_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // A bounded wait that runs out is counted and ends the run at once.
  task automatic timed_out(input int n);
    if (n >= 100) begin
      n_errors++;
      $display("ERROR at %0t: bus answer never came", $time);
      stop_test();
    end
  endtask : timed_out

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    timed_out(n);
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    timed_out(n);
    chk(s_axi_rdata, ed, "read data");
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  // The zero-delay receiver state is left open in oscillator feedback mode.
  task automatic chk_out(input logic [7:0] i, input logic [7:0] f);
    logic [1:0]  src;
    logic [13:0] exp;
    logic [13:0] got;
    src = f[4] ? 2'h0 : (f[5] ? 2'h1 : 2'h2);
    exp = {i[7], i[2] ? i[3] : 1'b1, i[2] ? i[4] : 1'b1, i[5], i[6],
           i[5] ? 1'b0 : f[0], i[6] ? 1'b0 : f[1], i[0],
           i[0] ? 1'b0 : i[1], f[2], f[2] ? 1'b0 : f[3],
           f[4] ? 1'b0 : !f[5], src};
    got = {test_rx_en_q, pri_rx_en_q, sec_rx_en_q, pri_diff_q, sec_diff_q,
           pri_pin_sel_q, sec_pin_sel_q, osc_diff_q, osc_neg_sel_q,
           zd_diff_q, zd_pin_sel_q, f[4] ? 1'b0 : zd_rx_en_q, fb_src_q};
    chk({18'h0, got}, {18'h0, exp}, "receiver outputs");
  endtask : chk_out

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    do_reset();
    chk_out(8'h00, 8'h00);
    axi_read(IRC_ADDR, 32'h0, RESP_OKAY);
    axi_read(FBC_ADDR, 32'h0, RESP_OKAY);
    $display("test reset values done");
    // Junk in the upper bytes must not reach the registers.
    for (int k = 0; k < 7; k++) begin
      axi_write(IRC_ADDR, {24'hA5C3E1, TAB[k][15:8]}, 4'hF, RESP_OKAY);
      axi_write(FBC_ADDR, {24'h5A3C1E, TAB[k][7:0]}, 4'hF, RESP_OKAY);
      chk_out(TAB[k][15:8], TAB[k][7:0]);
      chk_out(TAB[k][15:8], TAB[k][7:0]);
      chk_out(TAB[k][15:8], TAB[k][7:0]);
      axi_read(IRC_ADDR, {24'h0, TAB[k][15:8]}, RESP_OKAY);
      axi_read(FBC_ADDR, {24'h0, TAB[k][7:0]}, RESP_OKAY);
    end
    $display("test decode table done");
    axi_write(FBC_ADDR, 32'h0000_00FF, 4'hF, RESP_OKAY);
    axi_read(FBC_ADDR, 32'h0000_003F, RESP_OKAY);
    axi_write(IRC_ADDR, 32'h0000_0055, 4'hE, RESP_OKAY);
    axi_read(IRC_ADDR, {24'h0, TAB[6][15:8]}, RESP_OKAY);
    axi_write(12'h070, 32'h0000_00FF, 4'hF, RESP_SLVERR);
    axi_read(12'h070, 32'h0, RESP_SLVERR);
    axi_read(IRC_ADDR, {24'h0, TAB[6][15:8]}, RESP_OKAY);
    chk_out(TAB[6][15:8], 8'h3F);
    $display("test reserved and refused accesses done");
    do_reset();
    chk_out(8'h00, 8'h00);
    axi_read(IRC_ADDR, 32'h0, RESP_OKAY);
    axi_read(FBC_ADDR, 32'h0, RESP_OKAY);
    $display("test second reset done");
    stop_test();
  end
endmodule : testbench
